// >>> pkg/qport_pkg.sv
// constants, register map and carrier types of the quasi-bidirectional port set
package qport_pkg;

  // --------------------------------------------------------------------------
  // port widths
  // --------------------------------------------------------------------------
  localparam int unsigned WIDE_W   = 8;
  localparam int unsigned NARROW_W = 2;
  localparam int unsigned PIN_W    = 20;
  localparam int unsigned P1_LSB   = 0;
  localparam int unsigned P2_LSB   = 8;
  localparam int unsigned P3_LSB   = 10;
  localparam int unsigned P4_LSB   = 18;

  // --------------------------------------------------------------------------
  // alternate function bit positions within ports 1 and 3
  // --------------------------------------------------------------------------
  localparam int unsigned T2_CLK_BIT   = 0;
  localparam int unsigned T2_TRIG_BIT  = 1;
  localparam int unsigned CA_CLK_BIT   = 2;
  localparam int unsigned CA_CH0_BIT   = 3;
  localparam int unsigned CA_CH1_BIT   = 4;
  localparam int unsigned SER_DATA_BIT = 0;
  localparam int unsigned SER_TX_BIT   = 1;
  localparam int unsigned IRQ0_BIT     = 2;
  localparam int unsigned IRQ1_BIT     = 3;
  localparam int unsigned T0_CNT_BIT   = 4;
  localparam int unsigned P3_5_BIT     = 5;

  // --------------------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_P1    = 8'h00;
  localparam logic [7:0] ADDR_P2    = 8'h04;
  localparam logic [7:0] ADDR_P3    = 8'h08;
  localparam logic [7:0] ADDR_P4    = 8'h0C;
  localparam logic [7:0] ADDR_ACFG  = 8'h10;
  localparam logic [7:0] ADDR_P1PIN = 8'h14;
  localparam logic [7:0] ADDR_P2PIN = 8'h18;
  localparam logic [7:0] ADDR_P3PIN = 8'h1C;
  localparam logic [7:0] ADDR_P4PIN = 8'h20;
  localparam logic [7:0] ADDR_RST   = 8'h24;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------------------
  // reset values and timing
  // --------------------------------------------------------------------------
  localparam logic [PIN_W-1:0] LATCH_RST = 20'hFFFFF;
  localparam logic [7:0]       ACFG_RST  = 8'h00;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned OSC_PER_NS    = 10;
  localparam int unsigned BOOST_OSC     = 2;
  localparam int unsigned BOOST_CYC_I   = (BOOST_OSC * OSC_PER_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0]  BOOST_CYC     = 2'(BOOST_CYC_I < 1 ? 1 : BOOST_CYC_I);
  localparam int unsigned MCYC_OSC      = 12;
  localparam int unsigned RST_MCYC      = 2;
  localparam int unsigned RST_CYC_I     = RST_MCYC * MCYC_OSC * OSC_PER_NS * CLK_MHZ / 1000;
  localparam logic [5:0]  RST_CYC       = 6'(RST_CYC_I);

  // --------------------------------------------------------------------------
  // carrier types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic timer2_ext_clock_pin;
    logic timer2_ext_trigger_pin;
    logic counter_array_ext_clock_pin;
    logic counter_array_ch0_pin;
    logic counter_array_ch1_pin;
    logic serial_rx_pin;
    logic ext_irq0_pin;
    logic ext_irq1_pin;
    logic timer0_count_pin;
  } alt_in_t;

  typedef struct packed {
    logic counter_array_ch0_pin;
    logic counter_array_ch1_pin;
    logic serial_data_pin;
    logic serial_tx_pin;
    logic p3_5_alt;
  } alt_out_t;

endpackage : qport_pkg

// >>> rtl/qport_top.sv
// quasi-bidirectional port set with AXI4-Lite register access
`timescale 1ns/1ns
module qport_top
  import qport_pkg::*;
(
  input  wire logic             SYS_CLK,
  input  wire logic             RST,
  input  wire logic [7:0]       AWADDR,
  input  wire logic             AWVALID,
  output logic                  AWREADY,
  input  wire logic [31:0]      WDATA,
  input  wire logic [3:0]       WSTRB,
  input  wire logic             WVALID,
  output logic                  WREADY,
  output logic [1:0]            BRESP,
  output logic                  BVALID,
  input  wire logic             BREADY,
  input  wire logic [7:0]       ARADDR,
  input  wire logic             ARVALID,
  output logic                  ARREADY,
  output logic [31:0]           RDATA,
  output logic [1:0]            RRESP,
  output logic                  RVALID,
  input  wire logic             RREADY,
  input  wire logic [PIN_W-1:0] PIN_IN,
  output logic [PIN_W-1:0]      PIN_OUT,
  output logic [PIN_W-1:0]      PIN_OE_N,
  output logic [PIN_W-1:0]      PIN_WEAK_PU,
  output logic [PIN_W-1:0]      PIN_STRONG_PU,
  input  wire alt_out_t         ALT_OUT,
  output alt_in_t               ALT_IN,
  output logic                  CORE_RESET
);

  // --------------------------------------------------------------------------
  // reset qualification
  // --------------------------------------------------------------------------
  logic [5:0] rst_cnt_q;
  logic       core_rst_q;

  always_ff @(posedge SYS_CLK) begin
    if (!RST) begin
      rst_cnt_q <= '0;
    end else if (rst_cnt_q != RST_CYC) begin
      rst_cnt_q <= rst_cnt_q + 6'h01;
    end
  end

  // core reset only after the input has stood high two machine cycles
  always_ff @(posedge SYS_CLK) begin
    core_rst_q <= RST && (rst_cnt_q == RST_CYC - 6'h01 || rst_cnt_q == RST_CYC);
  end

  assign CORE_RESET = core_rst_q;

  // --------------------------------------------------------------------------
  // bus write channel
  // --------------------------------------------------------------------------
  logic       aw_held_q;
  logic       w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       wr_go;

  assign AWREADY = !aw_held_q && !bvalid_q;
  assign WREADY  = !w_held_q && !bvalid_q;
  assign wr_go   = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= AWADDR;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_held_q <= 1'b1;
        wdata_q  <= WDATA;
        wstrb_q  <= WSTRB;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a <= ADDR_RST) && (a[1:0] == 2'h0);
  endfunction : known_addr

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= known_addr(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign BVALID = bvalid_q;
  assign BRESP  = bresp_q;

  // --------------------------------------------------------------------------
  // port output latches and analog pin configuration
  // --------------------------------------------------------------------------
  logic [PIN_W-1:0] latch_q;
  logic [7:0]       analog_pin_config_q;
  logic             wr_lane0;

  assign wr_lane0 = wr_go && wstrb_q[0];

  // every reset returns all pins to weak-high inputs
  always_ff @(posedge SYS_CLK) begin
    if (RST || core_rst_q) begin
      latch_q <= LATCH_RST;
    end else if (wr_lane0) begin
      unique case (awaddr_q)
        ADDR_P1: latch_q[P1_LSB +: WIDE_W]   <= wdata_q[WIDE_W-1:0];
        ADDR_P2: latch_q[P2_LSB +: NARROW_W] <= wdata_q[NARROW_W-1:0];
        ADDR_P3: latch_q[P3_LSB +: WIDE_W]   <= wdata_q[WIDE_W-1:0];
        ADDR_P4: latch_q[P4_LSB +: NARROW_W] <= wdata_q[NARROW_W-1:0];
        default: latch_q <= latch_q;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST || core_rst_q) begin
      analog_pin_config_q <= ACFG_RST;
    end else if (wr_lane0 && awaddr_q == ADDR_ACFG) begin
      analog_pin_config_q <= wdata_q[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rd_d;

  assign ARREADY = !rvalid_q;

  // port offsets return the latch (read-modify-write view), pin offsets the pins
  always_comb begin
    rd_d = '0;
    unique case (ARADDR)
      ADDR_P1:    rd_d[WIDE_W-1:0]   = latch_q[P1_LSB +: WIDE_W];
      ADDR_P2:    rd_d[NARROW_W-1:0] = latch_q[P2_LSB +: NARROW_W];
      ADDR_P3:    rd_d[WIDE_W-1:0]   = latch_q[P3_LSB +: WIDE_W];
      ADDR_P4:    rd_d[NARROW_W-1:0] = latch_q[P4_LSB +: NARROW_W];
      ADDR_ACFG:  rd_d[7:0]          = analog_pin_config_q;
      ADDR_P1PIN: rd_d[WIDE_W-1:0]   = PIN_IN[P1_LSB +: WIDE_W];
      ADDR_P2PIN: rd_d[NARROW_W-1:0] = PIN_IN[P2_LSB +: NARROW_W];
      ADDR_P3PIN: rd_d[WIDE_W-1:0]   = PIN_IN[P3_LSB +: WIDE_W];
      ADDR_P4PIN: rd_d[NARROW_W-1:0] = PIN_IN[P4_LSB +: NARROW_W];
      ADDR_RST:   rd_d[0]            = core_rst_q;
      default:    rd_d = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_d;
      rresp_q  <= known_addr(ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign RVALID = rvalid_q;
  assign RDATA  = rdata_q;
  assign RRESP  = rresp_q;

  // --------------------------------------------------------------------------
  // alternate function outputs mapped onto pins
  // --------------------------------------------------------------------------
  logic [PIN_W-1:0] alt_drv;

  always_comb begin
    alt_drv = '1;
    alt_drv[P1_LSB + CA_CH0_BIT]   = ALT_OUT.counter_array_ch0_pin;
    alt_drv[P1_LSB + CA_CH1_BIT]   = ALT_OUT.counter_array_ch1_pin;
    alt_drv[P3_LSB + SER_DATA_BIT] = ALT_OUT.serial_data_pin;
    alt_drv[P3_LSB + SER_TX_BIT]   = ALT_OUT.serial_tx_pin;
    alt_drv[P3_LSB + P3_5_BIT]     = ALT_OUT.p3_5_alt;
  end

  // --------------------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------------------
  logic [PIN_W-1:0] drive_low_q;
  logic [PIN_W-1:0] latch_prev_q;
  logic [PIN_W-1:0] weak_pu;
  logic [1:0]       boost_cnt_q [PIN_W];

  // pin stage registered: follows the latch one cycle later
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      drive_low_q <= '0;
    end else begin
      drive_low_q <= ~(latch_q & alt_drv);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      latch_prev_q <= LATCH_RST;
    end else begin
      latch_prev_q <= latch_q;
    end
  end

  always_comb begin
    weak_pu = ~drive_low_q;
    weak_pu[P1_LSB +: WIDE_W] = ~drive_low_q[P1_LSB +: WIDE_W] & ~analog_pin_config_q;
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_boost
      always_ff @(posedge SYS_CLK) begin
        if (RST || core_rst_q) begin
          boost_cnt_q[gi] <= '0;
        end else if (latch_q[gi] && !latch_prev_q[gi]) begin
          boost_cnt_q[gi] <= BOOST_CYC;
        end else if (boost_cnt_q[gi] != 2'h0) begin
          boost_cnt_q[gi] <= boost_cnt_q[gi] - 2'h1;
        end
      end
      assign PIN_STRONG_PU[gi] = (boost_cnt_q[gi] != 2'h0) && !drive_low_q[gi];
    end
  endgenerate

  assign PIN_OUT     = '0;
  assign PIN_OE_N    = ~drive_low_q;
  assign PIN_WEAK_PU = weak_pu;

  // --------------------------------------------------------------------------
  // alternate function inputs
  // --------------------------------------------------------------------------
  // peripherals see the pin level; software keeps the latch high meanwhile
  always_comb begin
    ALT_IN.timer2_ext_clock_pin        = PIN_IN[P1_LSB + T2_CLK_BIT];
    ALT_IN.timer2_ext_trigger_pin      = PIN_IN[P1_LSB + T2_TRIG_BIT];
    ALT_IN.counter_array_ext_clock_pin = PIN_IN[P1_LSB + CA_CLK_BIT];
    ALT_IN.counter_array_ch0_pin       = PIN_IN[P1_LSB + CA_CH0_BIT];
    ALT_IN.counter_array_ch1_pin       = PIN_IN[P1_LSB + CA_CH1_BIT];
    ALT_IN.serial_rx_pin               = PIN_IN[P3_LSB + SER_DATA_BIT];
    ALT_IN.ext_irq0_pin                = PIN_IN[P3_LSB + IRQ0_BIT];
    ALT_IN.ext_irq1_pin                = PIN_IN[P3_LSB + IRQ1_BIT];
    ALT_IN.timer0_count_pin            = PIN_IN[P3_LSB + T0_CNT_BIT];
  end

endmodule : qport_top

// >>> test/qport_properties.sv
// concurrent checks on the port set's pins, alternate inputs and core reset
`timescale 1ns/1ns
module qport_properties
  import qport_pkg::*;
(
  input wire logic             SYS_CLK,
  input wire logic             RST,
  input wire logic             ARVALID,
  input wire logic             ARREADY,
  input wire logic             RVALID,
  input wire logic             RREADY,
  input wire logic [31:0]      RDATA,
  input wire logic [PIN_W-1:0] PIN_IN,
  input wire logic [PIN_W-1:0] PIN_OUT,
  input wire logic [PIN_W-1:0] PIN_OE_N,
  input wire logic [PIN_W-1:0] PIN_WEAK_PU,
  input wire logic [PIN_W-1:0] PIN_STRONG_PU,
  input wire alt_out_t         ALT_OUT,
  input wire alt_in_t          ALT_IN,
  input wire logic             CORE_RESET
);
  // --------------------------------------------------------------------------
  // reset length counter
  // --------------------------------------------------------------------------
  logic [5:0] rst_len_q  = 6'h00;
  logic       low_seen_q = 1'b0;
  always_ff @(posedge SYS_CLK) begin
    if (!RST) rst_len_q <= 6'h00;
    else if (rst_len_q != 6'h3F) rst_len_q <= rst_len_q + 6'h01;
  end
  // reset length is unknown until the input has once been seen low
  always_ff @(posedge SYS_CLK) begin
    if (!RST) low_seen_q <= 1'b1;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_t2_inputs : assert property (
    ALT_IN.timer2_ext_clock_pin == PIN_IN[0] && ALT_IN.timer2_ext_trigger_pin == PIN_IN[1]
    && ALT_IN.counter_array_ext_clock_pin == PIN_IN[2]) else $error("timer 2 inputs wrong");
  a_ca_inputs : assert property (
    ALT_IN.counter_array_ch0_pin == PIN_IN[3] && ALT_IN.counter_array_ch1_pin == PIN_IN[4])
    else $error("counter array channel inputs wrong");
  a_serial_irq_in : assert property (
    ALT_IN.serial_rx_pin == PIN_IN[10] && ALT_IN.ext_irq0_pin == PIN_IN[12]
    && ALT_IN.ext_irq1_pin == PIN_IN[13] && ALT_IN.timer0_count_pin == PIN_IN[14]) else $error("port 3 inputs wrong");
  a_alt_pulls_low : assert property (disable iff (RST || CORE_RESET)
    !ALT_OUT.serial_tx_pin |=> !PIN_OE_N[11]) else $error("alternate low did not pull pin");
  a_reset_idle : assert property (disable iff (1'b0)
    RST && $past(RST) && $past(RST, 2) |-> PIN_OE_N == LATCH_RST && PIN_STRONG_PU == '0)
    else $error("pins not idle in reset");
  a_core_reset_len : assert property (disable iff (1'b0)
    low_seen_q && $past(RST) |-> CORE_RESET == (rst_len_q >= RST_CYC)) else $error("core reset length wrong");
  a_boost_two : assert property (
    $rose(PIN_STRONG_PU[0]) |=> PIN_STRONG_PU[0] ##1 !PIN_STRONG_PU[0]) else $error("boost not two cycles");
  a_out_low : assert property (
    PIN_OUT == '0) else $error("pin driven high");
  a_weak_pu_ports : assert property (
    PIN_WEAK_PU[PIN_W-1:P2_LSB] == PIN_OE_N[PIN_W-1:P2_LSB]) else $error("pull-up missing");
  a_read_answer : assert property (
    ARVALID && ARREADY && !RVALID |=> RVALID) else $error("read not answered");
  a_read_hold : assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read data dropped");
endmodule : qport_properties

bind qport_top qport_properties u_qport_properties (.SYS_CLK(SYS_CLK), .RST(RST), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
  .PIN_OE_N(PIN_OE_N), .PIN_WEAK_PU(PIN_WEAK_PU), .PIN_STRONG_PU(PIN_STRONG_PU), .ALT_OUT(ALT_OUT),
  .ALT_IN(ALT_IN), .CORE_RESET(CORE_RESET));

// >>> test/pin_partner.sv
// board model on the port pins: pulls, outside drivers, floating lines
`timescale 1ns/1ns
module pin_partner
  import qport_pkg::*;
(
  input  wire logic             clk,
  input  wire logic [PIN_W-1:0] oe_n,
  input  wire logic [PIN_W-1:0] weak_pu,
  input  wire logic [PIN_W-1:0] strong_pu,
  input  wire logic [PIN_W-1:0] pull_low,
  output logic      [PIN_W-1:0] level
);
  // unpulled, undriven lines wander every cycle
  logic [PIN_W-1:0] float_q = '0;
  always_ff @(posedge clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (!oe_n[i] || pull_low[i]) level[i] = 1'b0;
      else if (weak_pu[i] || strong_pu[i]) level[i] = 1'b1;
      else level[i] = float_q[i];
    end
  end
endmodule : pin_partner

// >>> test/tb_top.sv
// self-checking bench for the quasi-bidirectional port set
`timescale 1ns/1ns
module tb_top
  import qport_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, core_reset;
  logic [1:0] bresp, rresp;
  logic [PIN_W-1:0] pin_in, pin_out, oe_n, weak_pu, strong_pu, pull_low = '0;
  alt_out_t alt_out = '1;
  alt_in_t alt_in;
  int failures = 0, checks_done = 0;
  always #5 sys_clk = ~sys_clk;
  qport_top u_qport_top (.SYS_CLK(sys_clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(oe_n),
    .PIN_WEAK_PU(weak_pu), .PIN_STRONG_PU(strong_pu), .ALT_OUT(alt_out), .ALT_IN(alt_in), .CORE_RESET(core_reset));
  pin_partner u_pin_partner (.clk(sys_clk), .oe_n(oe_n), .weak_pu(weak_pu), .strong_pu(strong_pu),
    .pull_low(pull_low), .level(pin_in));
  // --------------------------------------------------------------------------
  // bus and compare tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'h3;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        done = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'h3;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rresp;
        d = rdata;
        done = 1'b1;
        rready <= 1'b0;
      end
    end
  endtask : axi_rd
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_state;
    logic [31:0] d;
    logic [1:0] r;
    for (int p = 0; p < 4; p++) begin
      axi_rd(8'(4 * p), d, r);
      chk("latch_rst", (p % 2) ? 32'h3 : 32'hFF, d);
    end
    axi_rd(ADDR_RST, d, r);
    chk("core_rst_short", 32'h0, d);
    chk("oe_rst", 32'(LATCH_RST), 32'(oe_n));
  endtask : t_reset_state
  task automatic t_latch_pin;
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] pe [4] = '{32'h85, 32'h1, 32'hA4, 32'h1};
    pull_low <= 20'h00420;
    for (int p = 0; p < 4; p++) begin
      axi_wr(8'(4 * p), 32'hFFFF_FFA5, r);
      chk("wr_resp", 32'(RESP_OKAY), 32'(r));
    end
    repeat (2) @(posedge sys_clk);
    #1;
    chk("oe_latch", 32'({2'h1, 8'hA5, 2'h1, 8'hA5}), 32'(oe_n));
    for (int p = 0; p < 4; p++) begin
      axi_rd(8'(4 * p), d, r);
      chk("latch_rd", (p % 2) ? 32'h1 : 32'hA5, d);
      axi_rd(ADDR_P1PIN + 8'(4 * p), d, r);
      chk("pin_rd", pe[p], d);
    end
    pull_low <= '0;
  endtask : t_latch_pin
  task automatic t_boost;
    logic [1:0] r;
    int hi0, hi1;
    hi0 = 0;
    hi1 = 0;
    axi_wr(ADDR_P1, 32'h00, r);
    axi_wr(ADDR_P1, 32'h01, r);
    for (int n = 0; n < 8; n++) begin
      #1;
      if (strong_pu[0] === 1'b1) hi0++;
      if (strong_pu[1] !== 1'b0) hi1++;
      @(posedge sys_clk);
    end
    chk("boost_rise", 32'(BOOST_CYC), 32'(hi0));
    chk("boost_still", 32'h0, 32'(hi1));
  endtask : t_boost
  task automatic t_analog;
    logic [31:0] d;
    logic [1:0] r;
    for (int p = 0; p < 4; p++) axi_wr(8'(4 * p), 32'hFF, r);
    axi_wr(ADDR_ACFG, 32'h0F, r);
    #1;
    chk("weak_pu_analog", 32'h000FFFF0, 32'(weak_pu));
    axi_rd(ADDR_ACFG, d, r);
    chk("acfg_rd", 32'h0F, d);
    axi_wr(ADDR_ACFG, 32'h00, r);
  endtask : t_analog
  task automatic t_alt;
    logic [1:0] r;
    logic [PIN_W-1:0] lv;
    for (int p = 0; p < 4; p++) axi_wr(8'(4 * p), 32'hFF, r);
    alt_out <= '0;
    pull_low <= 20'h0A5A5;
    repeat (2) @(posedge sys_clk);
    #1;
    lv = ~20'h0A5A5 & 20'hF73E7;
    chk("oe_alt", 32'h000F73E7, 32'(oe_n));
    chk("alt_in", 32'({lv[0], lv[1], lv[2], lv[3], lv[4], lv[10], lv[12], lv[13], lv[14]}), 32'(alt_in));
    @(posedge sys_clk);
    alt_out <= '1;
    pull_low <= '0;
  endtask : t_alt
  task automatic t_refuse;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(8'h28, 32'h0, r);
    chk("unmapped_wr", 32'(RESP_SLVERR), 32'(r));
    axi_rd(8'h30, d, r);
    chk("unmapped_rd", 32'(RESP_SLVERR), 32'(r));
    axi_wr(8'h01, 32'h0, r);
    chk("unaligned_wr", 32'(RESP_SLVERR), 32'(r));
    axi_rd(ADDR_P1, d, r);
    chk("p1_kept", 32'hFF, d);
  endtask : t_refuse
  task automatic t_long_reset;
    logic [31:0] d;
    logic [1:0] r;
    int hi;
    hi = 0;
    axi_wr(ADDR_P1, 32'h00, r);
    rst <= 1'b1;
    for (int n = 0; n < 30; n++) begin
      @(posedge sys_clk);
      #1;
      if (strong_pu !== '0) hi++;
      if (n == 10) chk("core_rst_early", 32'h0, 32'(core_reset));
    end
    chk("core_rst_long", 32'h1, 32'(core_reset));
    chk("boost_in_rst", 32'h0, 32'(hi));
    @(posedge sys_clk);
    rst <= 1'b0;
    axi_rd(ADDR_P1, d, r);
    chk("latch_after_rst", 32'hFF, d);
    axi_rd(ADDR_RST, d, r);
    chk("core_rst_off", 32'h0, d);
  endtask : t_long_reset
  // --------------------------------------------------------------------------
  // run control
  // --------------------------------------------------------------------------
  task automatic summarize;
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    failures++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_state();
    t_latch_pin();
    t_boost();
    t_analog();
    t_alt();
    t_refuse();
    t_long_reset();
    summarize();
  end
endmodule : tb_top
